// File: rtl/phap_pkg.sv
// Package for the palette host access port: port offsets, fields, states.
// Assumes a single 50 MHz clock domain and a byte-wide host I/O bus.
package phap_pkg;

  // Port addresses
  localparam logic [15:0] PORT_MASK       = 16'h03c6;
  localparam logic [15:0] PORT_READ_INDEX = 16'h03c7;
  localparam logic [15:0] PORT_WRITE_IDX  = 16'h03c8;
  localparam logic [15:0] PORT_DATA       = 16'h03c9;

  // Field layout of an entry
  localparam int COMP_W  = 6;
  localparam int ENTRY_W = 18;
  localparam int RED_LSB = 12;
  localparam int GRN_LSB = 6;
  localparam int BLU_LSB = 0;

  // Reset values and status codes
  localparam logic [7:0] MASK_RESET   = 8'hff;
  localparam logic [7:0] INDEX_RESET  = 8'h00;
  localparam logic [1:0] STATUS_READ  = 2'b00;
  localparam logic [1:0] STATUS_WRITE = 2'b11;

  // Component sequencing
  typedef enum logic [2:0] {
    COMP_RED   = 3'b001,
    COMP_GREEN = 3'b010,
    COMP_BLUE  = 3'b100
  } phap_comp_type;

  // Host access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } phap_req_type;

  // Palette memory port
  typedef struct packed {
    logic              we;
    logic [7:0]        waddr;
    logic [ENTRY_W-1:0] wdata;
    logic [7:0]        raddr;
  } phap_mem_req_type;

endpackage

// File: rtl/phap_palette_ram.sv
// 256 x 18 palette memory with one write port and two registered read ports.
// Assumes all accesses are synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module phap_palette_ram (
  // Clock
  input  wire logic        mclk,
  // Host side
  input  wire phap_pkg::phap_mem_req_type host_req,
  output var  logic [17:0] host_rdata,
  // Refresh side
  input  wire logic [7:0]  refresh_addr,
  output var  logic [17:0] refresh_rdata
);

  logic [17:0] mem [0:255];

  always_ff @(posedge mclk) begin
    if (host_req.we) begin
      mem[host_req.waddr] <= host_req.wdata;
    end
    host_rdata    <= mem[host_req.raddr];
    refresh_rdata <= mem[refresh_addr];
  end

endmodule
`default_nettype wire

// File: rtl/phap_access_port.sv
// Host access port of the colour palette: mask, index, status and data ports.
// Assumes host read/write strobes are one-cycle pulses synchronous to mclk,
// and the refresh pixel value is produced on mclk as well.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Reading the status port gives 00 in its low bits when the read index port was written last.
// - Reading the status port gives 11 in its low bits when the write index port was written last.
// - Four ports are decoded: mask 3c6, read index or status 3c7, write index 3c8, data 3c9.
// - Writing the read index fetches that entry into the 18-bit holding register.
// - Each data read returns one 6-bit component in the low bits with the top two bits zero.
// - Data reads of an entry return red, then green, then blue.
// - After the third read the read index advances by one.
// - Data writes fill the holding register with the low six bits in red, green, blue order.
// - After three writes the holding register is stored at the write index.
// - After each stored entry the write index advances by one.
// - The refresh pixel is ANDed with the mask to index the palette, host access unaffected.
// - Reading the status port never disturbs a read or write sequence.
module phap_access_port (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Host I/O
  input  wire logic        host_rd,
  input  wire logic        host_wr,
  input  wire logic [15:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  output var  logic [7:0]  host_rdata,
  output var  logic        host_rvalid,
  // Display refresh
  input  wire logic [7:0]  pixel_value,
  output var  logic [17:0] pixel_colour
);

  typedef struct packed {
    logic [7:0]                 mask_reg;
    logic [7:0]                 read_index_reg;
    logic [7:0]                 write_index_reg;
    logic [1:0]                 status_reg;
    logic [17:0]                hold_reg;
    phap_pkg::phap_comp_type    rd_comp_reg;
    phap_pkg::phap_comp_type    wr_comp_reg;
    logic                       fetch_reg;
    logic                       advance_fetch_reg;
    logic                       we_reg;
    logic [17:0]                we_data_reg;
    logic [7:0]                 we_addr_reg;
    logic [7:0]                 rdata_reg;
    logic                       rvalid_reg;
    logic [7:0]                 refresh_idx_reg;
    logic [17:0]                colour_reg;
  } phap_state_type;

  phap_state_type             state_reg;
  phap_state_type             state_next;
  phap_pkg::phap_req_type     req;
  phap_pkg::phap_mem_req_type mem_req;
  logic [17:0]                ram_rdata;
  logic [17:0]                refresh_rdata;

  always_comb begin
    req.rd    = host_rd;
    req.wr    = host_wr;
    req.addr  = host_addr;
    req.wdata = host_wdata;
  end

  always_comb begin
    mem_req.we    = state_reg.we_reg;
    mem_req.waddr = state_reg.we_addr_reg;
    mem_req.wdata = state_reg.we_data_reg;
    mem_req.raddr = state_reg.read_index_reg;
  end

  phap_palette_ram u_ram (
    .mclk          (mclk),
    .host_req      (mem_req),
    .host_rdata    (ram_rdata),
    .refresh_addr  (state_reg.refresh_idx_reg),
    .refresh_rdata (refresh_rdata)
  );

  always_comb begin
    state_next            = state_reg;
    state_next.we_reg     = 1'b0;
    state_next.rvalid_reg = 1'b0;
    state_next.fetch_reg  = 1'b0;
    state_next.advance_fetch_reg = 1'b0;
    // Mask applies to refresh lookup only
    state_next.refresh_idx_reg = pixel_value & state_reg.mask_reg;
    state_next.colour_reg      = refresh_rdata;

    // RAM read data lands one cycle after the index is presented
    if (state_reg.fetch_reg) begin
      state_next.hold_reg = ram_rdata;
    end
    if (state_reg.advance_fetch_reg) begin
      state_next.fetch_reg = 1'b1;
    end

    if (req.wr) begin
      case (req.addr)
        phap_pkg::PORT_MASK: begin
          state_next.mask_reg = req.wdata;
        end
        phap_pkg::PORT_READ_INDEX: begin
          state_next.read_index_reg = req.wdata;
          state_next.status_reg     = phap_pkg::STATUS_READ;
          state_next.rd_comp_reg    = phap_pkg::COMP_RED;
          state_next.wr_comp_reg    = phap_pkg::COMP_RED;
          state_next.advance_fetch_reg = 1'b1;
        end
        phap_pkg::PORT_WRITE_IDX: begin
          state_next.write_index_reg = req.wdata;
          state_next.status_reg      = phap_pkg::STATUS_WRITE;
          state_next.rd_comp_reg     = phap_pkg::COMP_RED;
          state_next.wr_comp_reg     = phap_pkg::COMP_RED;
        end
        phap_pkg::PORT_DATA: begin
          case (state_reg.wr_comp_reg)
            phap_pkg::COMP_RED: begin
              state_next.hold_reg[phap_pkg::RED_LSB +: phap_pkg::COMP_W] = req.wdata[5:0];
              state_next.wr_comp_reg = phap_pkg::COMP_GREEN;
            end
            phap_pkg::COMP_GREEN: begin
              state_next.hold_reg[phap_pkg::GRN_LSB +: phap_pkg::COMP_W] = req.wdata[5:0];
              state_next.wr_comp_reg = phap_pkg::COMP_BLUE;
            end
            phap_pkg::COMP_BLUE: begin
              state_next.we_reg      = 1'b1;
              state_next.we_addr_reg = state_reg.write_index_reg;
              state_next.we_data_reg = {state_reg.hold_reg[17:6], req.wdata[5:0]};
              state_next.hold_reg[phap_pkg::BLU_LSB +: phap_pkg::COMP_W] = req.wdata[5:0];
              state_next.write_index_reg = state_reg.write_index_reg + 8'h01;
              state_next.wr_comp_reg = phap_pkg::COMP_RED;
            end
            default: begin
              // Illegal component code falls back to red
              state_next.wr_comp_reg = phap_pkg::COMP_RED;
            end
          endcase
        end
        default: begin
        end
      endcase
    end else if (req.rd) begin
      state_next.rvalid_reg = 1'b1;
      state_next.rdata_reg  = 8'h00;
      case (req.addr)
        phap_pkg::PORT_MASK: begin
          state_next.rdata_reg = state_reg.mask_reg;
        end
        phap_pkg::PORT_READ_INDEX: begin
          // Pure read of status, no side effect
          state_next.rdata_reg = {6'h00, state_reg.status_reg};
        end
        phap_pkg::PORT_WRITE_IDX: begin
          state_next.rdata_reg = state_reg.write_index_reg;
        end
        phap_pkg::PORT_DATA: begin
          case (state_reg.rd_comp_reg)
            phap_pkg::COMP_RED: begin
              state_next.rdata_reg   = {2'b00, state_reg.hold_reg[phap_pkg::RED_LSB +: phap_pkg::COMP_W]};
              state_next.rd_comp_reg = phap_pkg::COMP_GREEN;
            end
            phap_pkg::COMP_GREEN: begin
              state_next.rdata_reg   = {2'b00, state_reg.hold_reg[phap_pkg::GRN_LSB +: phap_pkg::COMP_W]};
              state_next.rd_comp_reg = phap_pkg::COMP_BLUE;
            end
            phap_pkg::COMP_BLUE: begin
              state_next.rdata_reg      = {2'b00, state_reg.hold_reg[phap_pkg::BLU_LSB +: phap_pkg::COMP_W]};
              state_next.rd_comp_reg    = phap_pkg::COMP_RED;
              state_next.read_index_reg = state_reg.read_index_reg + 8'h01;
              state_next.advance_fetch_reg = 1'b1;
            end
            default: begin
              // Illegal component code falls back to red
              state_next.rd_comp_reg = phap_pkg::COMP_RED;
            end
          endcase
        end
        default: begin
          state_next.rvalid_reg = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg.mask_reg          <= phap_pkg::MASK_RESET;
      state_reg.read_index_reg    <= phap_pkg::INDEX_RESET;
      state_reg.write_index_reg   <= phap_pkg::INDEX_RESET;
      state_reg.status_reg        <= phap_pkg::STATUS_READ;
      state_reg.hold_reg          <= 18'h00000;
      state_reg.rd_comp_reg       <= phap_pkg::COMP_RED;
      state_reg.wr_comp_reg       <= phap_pkg::COMP_RED;
      state_reg.fetch_reg         <= 1'b0;
      state_reg.advance_fetch_reg <= 1'b0;
      state_reg.we_reg            <= 1'b0;
      state_reg.we_data_reg       <= 18'h00000;
      state_reg.we_addr_reg       <= 8'h00;
      state_reg.rdata_reg         <= 8'h00;
      state_reg.rvalid_reg        <= 1'b0;
      state_reg.refresh_idx_reg   <= 8'h00;
      state_reg.colour_reg        <= 18'h00000;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state flops
  assign host_rdata   = state_reg.rdata_reg;
  assign host_rvalid  = state_reg.rvalid_reg;
  assign pixel_colour = state_reg.colour_reg;

endmodule
`default_nettype wire

// File: sim/phap_access_port_asserts.sv
// Checker for the palette host access port, bound to its top ports.
// Assumes one mclk domain with synchronous active-low rst_b.
`timescale 1ns/100ps
`default_nettype none
module phap_access_port_asserts (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // Host I/O
  input wire logic        host_rd,
  input wire logic        host_wr,
  input wire logic [15:0] host_addr,
  input wire logic [7:0]  host_wdata,
  input wire logic [7:0]  host_rdata,
  input wire logic        host_rvalid,
  // Display refresh
  input wire logic [7:0]  pixel_value,
  input wire logic [17:0] pixel_colour
);
  logic       mode_reg;
  logic [7:0] mask_reg;
  logic [7:0] widx_reg;
  logic [1:0] cnt_reg;
  // Shadow of mode, mask, write index and component count
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_reg <= 1'b0;
      mask_reg <= 8'hff;
      widx_reg <= 8'h00;
      cnt_reg  <= 2'h0;
    end else if (host_wr) begin
      if (host_addr == phap_pkg::PORT_READ_INDEX) begin
        mode_reg <= 1'b0;
        cnt_reg  <= 2'h0;
      end
      if (host_addr == phap_pkg::PORT_WRITE_IDX) begin
        mode_reg <= 1'b1;
        widx_reg <= host_wdata;
        cnt_reg  <= 2'h0;
      end
      if (host_addr == phap_pkg::PORT_MASK) mask_reg <= host_wdata;
      if (host_addr == phap_pkg::PORT_DATA) begin
        cnt_reg <= (cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
        if (cnt_reg == 2'h2) widx_reg <= widx_reg + 8'h01;
      end
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence rd_of(logic [15:0] a);
    host_rd && !host_wr && host_addr == a;
  endsequence
  sequence rd_mapped;
    host_rd && !host_wr && host_addr inside {[16'h03c6:16'h03c9]};
  endsequence
  read_answer_a: assert property (rd_mapped |=> host_rvalid) else $error("no answer to read");
  unmapped_quiet_a: assert property (
    host_rvalid |-> $past(host_rd && !host_wr && host_addr inside {[16'h03c6:16'h03c9]}))
    else $error("answer without mapped read");
  status_read_a: assert property (rd_of(16'h03c7) ##0 !mode_reg |=> host_rdata[1:0] == 2'b00)
    else $error("status not read mode");
  status_write_a: assert property (rd_of(16'h03c7) ##0 mode_reg |=> host_rdata[1:0] == 2'b11)
    else $error("status not write mode");
  status_upper_a: assert property (rd_of(16'h03c7) |=> host_rdata[7:2] == 6'h00)
    else $error("status upper bits set");
  data_upper_a: assert property (rd_of(16'h03c9) |=> host_rdata[7:6] == 2'b00)
    else $error("data upper bits set");
  mask_read_a: assert property (rd_of(16'h03c6) |=> host_rdata == mask_reg) else $error("mask mismatch");
  widx_read_a: assert property (rd_of(16'h03c8) ##0 cnt_reg == 2'h0 |=> host_rdata == widx_reg)
    else $error("write index mismatch");
endmodule
`default_nettype wire

// File: sim/phap_host_model.sv
// Host CPU model: byte I/O writes and reads with one-cycle strobes.
// Assumes the access port answers reads one edge after the strobe.
`timescale 1ns/100ps
`default_nettype none
module phap_host_model (
  // Clock
  input wire logic        mclk,
  // Host bus
  output var logic        host_rd,
  output var logic        host_wr,
  output var logic [15:0] host_addr,
  output var logic [7:0]  host_wdata,
  input wire logic [7:0]  host_rdata,
  input wire logic        host_rvalid
);
  int reads;
  initial begin
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = 16'h0000;
    host_wdata = 8'h00;
    reads = 0;
  end
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    #2 host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(posedge mclk);
    #2 host_wr = 1'b0;
    host_wdata = ~d;
    if (a == phap_pkg::PORT_WRITE_IDX) reads = 0;
    if (a == phap_pkg::PORT_READ_INDEX) begin
      reads = 0;
      repeat (3) @(posedge mclk);
    end
  endtask
  task automatic get(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    #2 host_rd = 1'b1;
    host_addr = a;
    @(posedge mclk);
    #2 d = host_rdata;
    v = host_rvalid;
    host_rd = 1'b0;
    if (a == phap_pkg::PORT_DATA && ++reads == 3) begin
      reads = 0;
      repeat (3) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// File: sim/phap_access_port_test.sv
// Self-checking bench for the palette host access port.
// Assumes the host model drives the bus and a 50 MHz mclk.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module phap_access_port_test;
  logic mclk, rst_b, host_rd, host_wr, host_rvalid, v;
  logic [15:0] host_addr;
  logic [7:0] host_wdata, host_rdata, pixel_value, d, r, g, b;
  logic [17:0] pixel_colour;
  int fails, comparisons, cyc;
  int pal[int];
  phap_access_port dut (.mclk, .rst_b, .host_rd, .host_wr, .host_addr, .host_wdata,
    .host_rdata, .host_rvalid, .pixel_value, .pixel_colour);
  phap_host_model host (.mclk, .host_rd, .host_wr, .host_addr, .host_wdata, .host_rdata, .host_rvalid);
  task automatic conclude();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (++cyc == 2000) begin
    fails++;
    conclude();
  end
  initial begin
    rst_b = 1'b0;
    pixel_value = 8'h00;
    d = 8'($urandom(32'h2a1b));
    repeat (3) @(posedge mclk);
    #2 rst_b = 1'b1;
    host.get(phap_pkg::PORT_MASK, d, v);
    `CHK("mask reset", phap_pkg::MASK_RESET, d)
    host.put(phap_pkg::PORT_MASK, 8'h4f);
    host.get(phap_pkg::PORT_MASK, d, v);
    `CHK("mask", 8'h4f, d)
    // Partial entry, then restart at red
    host.put(phap_pkg::PORT_WRITE_IDX, 8'h40);
    host.put(phap_pkg::PORT_DATA, 8'hff);
    host.put(phap_pkg::PORT_WRITE_IDX, 8'h40);
    for (int e = 0; e < 2; e++) begin
      r = 8'($urandom());
      g = 8'($urandom());
      b = 8'($urandom());
      host.put(phap_pkg::PORT_DATA, r);
      host.get(phap_pkg::PORT_READ_INDEX, d, v);
      `CHK("status", 8'h03, d)
      host.put(phap_pkg::PORT_DATA, g);
      host.put(phap_pkg::PORT_DATA, b);
      pal[64 + e] = int'({r[5:0], g[5:0], b[5:0]});
    end
    host.get(phap_pkg::PORT_WRITE_IDX, d, v);
    `CHK("write index", 8'h42, d)
    pixel_value = 8'hc1;
    repeat (4) @(posedge mclk);
    #1 `CHK("colour", 18'(pal[65]), pixel_colour)
    // Partial read of the next entry, then restart at red
    host.put(phap_pkg::PORT_READ_INDEX, 8'h41);
    host.get(phap_pkg::PORT_DATA, d, v);
    `CHK("first red", 8'((pal[65] >> 12) & 'h3f), d)
    host.put(phap_pkg::PORT_READ_INDEX, 8'h40);
    host.get(phap_pkg::PORT_READ_INDEX, d, v);
    `CHK("status", 8'h00, d)
    for (int e = 0; e < 2; e++)
      for (int c = 0; c < 3; c++) begin
        host.get(phap_pkg::PORT_DATA, d, v);
        `CHK("component", 8'((pal[64 + e] >> (12 - 6 * c)) & 'h3f), d)
        `CHK("valid", 1'b1, v)
        if (c == 1) begin
          host.get(phap_pkg::PORT_READ_INDEX, d, v);
          `CHK("status", 8'h00, d)
        end
      end
    host.get(16'h03ca, d, v);
    `CHK("unmapped", 1'b0, v)
    conclude();
  end
endmodule
bind phap_access_port phap_access_port_asserts chk (.mclk, .rst_b, .host_rd, .host_wr, .host_addr,
  .host_wdata, .host_rdata, .host_rvalid, .pixel_value, .pixel_colour);
`default_nettype wire
